// ===== anr_defs.vh
// Constants for the auto-negotiation result and management address register.
`ifndef ANR_DEFS_VH
`define ANR_DEFS_VH
`define ANR_REG_INDEX 5'h11
`define ANR_BIT_FFDX 15
`define ANR_BIT_FHDX 14
`define ANR_BIT_SFDX 13
`define ANR_BIT_SHDX 12
`define ANR_ADDR_MSB 8
`define ANR_ADDR_LSB 4
`define ANR_CODE_MSB 3
`define ANR_CODE_LSB 0
`define ANR_RES_RESET 4'hF
`define ANR_CODE_RESET 4'h0
`define ANR_CODE_IDLE 4'h0
`define ANR_CODE_ABIL 4'h1
`define ANR_CODE_ACK 4'h2
`define ANR_CODE_ACK_FAIL 4'h3
`define ANR_CODE_CONS 4'h4
`define ANR_CODE_CONS_FAIL 4'h5
`define ANR_CODE_PD_OK 4'h6
`define ANR_CODE_PD_FAIL 4'h7
`define ANR_CODE_DONE 4'h8
`define ANR_MODE_FFDX 2'h3
`define ANR_MODE_FHDX 2'h2
`define ANR_MODE_SFDX 2'h1
`define ANR_MODE_SHDX 2'h0
`define ANR_RES_FFDX 4'h8
`define ANR_RES_FHDX 4'h4
`define ANR_RES_SFDX 4'h2
`define ANR_RES_SHDX 4'h1
`define ANR_FLAG_RESET 1'h1
`define ANR_ADDR_RESET 5'h00
`define ANR_RDATA_RESET 16'h0000
`define ANR_RDATA_IDLE 16'h0000
`define ANR_RSVD_ZERO 3'h0
`define ANR_FILL_RESET 2'h0
`define ANR_FILL_STEP 2'h1
`define ANR_STRAP_FILL 2'h3
`endif

// ===== anr_addr_latch.v
// Management address holder: strap capture after reset, then software writable.
`timescale 1ns/1ps
`default_nettype none
`include "anr_defs.vh"
module anr_addr_latch (
    input wire core_clk,
    input wire reset,
    input wire [4:0] strap_addr,
    input wire wr_en,
    input wire [4:0] wr_addr,
    output reg [4:0] addr_r
);
    reg [4:0] strap_s1_r;
    reg [4:0] strap_s2_r;
    reg [4:0] strap_s3_r;
    reg [1:0] fill_r;
    reg captured_r;
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            strap_s1_r <= `ANR_ADDR_RESET;
            strap_s2_r <= `ANR_ADDR_RESET;
            strap_s3_r <= `ANR_ADDR_RESET;
            fill_r <= `ANR_FILL_RESET;
            captured_r <= 1'h0;
            addr_r <= `ANR_ADDR_RESET;
        end else begin
            strap_s1_r <= strap_addr;
            strap_s2_r <= strap_s1_r;
            strap_s3_r <= strap_s2_r;
            // The stages start from reset values, so agreement only counts once real samples fill them.
            if (fill_r != `ANR_STRAP_FILL) begin
                fill_r <= fill_r + `ANR_FILL_STEP;
            end
            if (!captured_r) begin
                if (fill_r == `ANR_STRAP_FILL && strap_s2_r == strap_s3_r) begin
                    captured_r <= 1'h1;
                    addr_r <= strap_s2_r;
                end
            end else if (wr_en) begin
                addr_r <= wr_addr;
            end
        end
    end
endmodule // anr_addr_latch
`default_nettype wire

// ===== anr_status_reg.v
// Auto-negotiation result, management address and progress code register.
//
// Contract
// - Bit 15 flags 100 full duplex result.
// - Bit 14 flags 100 half duplex result.
// - Bit 13 flags 10 full duplex result.
// - Bit 12 flags 10 half duplex result.
// - Bits 8..4 hold address, MSB first.
// - Bits 3..0 show live negotiation progress.
// - Progress codes idle through completed, 0..8.
`timescale 1ns/1ps
`default_nettype none
`include "anr_defs.vh"
module anr_status_reg (
    input wire core_clk,
    input wire reset,
    input wire [4:0] strap_phy_address,
    input wire [4:0] reg_index,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    input wire an_done,
    input wire [1:0] an_mode,
    input wire [3:0] an_progress,
    output reg [15:0] reg_rdata,
    output reg [4:0] mgmt_phy_address,
    output reg res_fast_full_duplex,
    output reg res_fast_half_duplex,
    output reg res_slow_full_duplex,
    output reg res_slow_half_duplex,
    output reg [3:0] autoneg_progress_code
);
    // A read strobe taken on one edge shows its word on reg_rdata after that edge and holds it
    // until the next read. A completion taken on one edge updates the read image after that edge
    // and the flag pins one edge later. The strap address is taken on the fourth edge after
    // reset release, once the last two synchroniser stages agree.
    wire hit;
    wire wr_hit;
    wire rd_hit;
    wire rd_miss;
    wire [4:0] addr_q;
    wire [4:0] addr_wr_field;
    wire [2:0] rsvd_field;
    wire [15:0] image;
    reg [3:0] mode_onehot;
    reg [3:0] res_r;
    reg [3:0] res_nxt;
    reg [3:0] code_nxt;
    reg [15:0] rdata_nxt;

    assign hit = reg_index == `ANR_REG_INDEX;
    assign wr_hit = reg_wr && hit;
    assign rd_hit = reg_rd && hit;
    assign rd_miss = reg_rd && !hit;

    // Writes skip reserved
    // Only the address field takes written data, so every other written bit simply goes nowhere.
    assign addr_wr_field = reg_wdata[`ANR_ADDR_MSB:`ANR_ADDR_LSB];

    // Address field write
    // A write that lands on or before the capture edge is lost; software must wait until the fifth edge after reset release.
    anr_addr_latch u_addr (
        .core_clk(core_clk),
        .reset(reset),
        .strap_addr(strap_phy_address),
        .wr_en(wr_hit),
        .wr_addr(addr_wr_field),
        .addr_r(addr_q)
    );

    // One-hot mode decode
    // Each mode code owns one flag, so two flags can never be raised by one result.
    always @* begin
        mode_onehot = `ANR_RES_SHDX;
        case (an_mode)
            `ANR_MODE_FFDX: begin
                mode_onehot = `ANR_RES_FFDX;
            end
            `ANR_MODE_FHDX: begin
                mode_onehot = `ANR_RES_FHDX;
            end
            `ANR_MODE_SFDX: begin
                mode_onehot = `ANR_RES_SFDX;
            end
            `ANR_MODE_SHDX: begin
                mode_onehot = `ANR_RES_SHDX;
            end
            default: begin
                mode_onehot = `ANR_RES_SHDX;
            end
        endcase
    end

    // Result taken on completion
    // Between completions the flags keep the last result instead of following the mode inputs.
    always @* begin
        res_nxt = res_r;
        if (an_done) begin
            res_nxt = mode_onehot;
        end
    end

    // Only documented codes pass
    // A code past the last defined state means nothing to software, so the last good one stays.
    always @* begin
        code_nxt = autoneg_progress_code;
        if (an_progress <= `ANR_CODE_DONE) begin
            code_nxt = an_progress;
        end
    end

    assign rsvd_field = `ANR_RSVD_ZERO;
    assign image = {res_r, rsvd_field, addr_q, autoneg_progress_code};

    // Other registers share the read port, so a read aimed elsewhere returns zero.
    always @* begin
        rdata_nxt = reg_rdata;
        if (rd_hit) begin
            rdata_nxt = image;
        end else if (rd_miss) begin
            rdata_nxt = `ANR_RDATA_IDLE;
        end
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            res_r <= `ANR_RES_RESET;
        end else begin
            res_r <= res_nxt;
        end
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            autoneg_progress_code <= `ANR_CODE_RESET;
        end else begin
            autoneg_progress_code <= code_nxt;
        end
    end

    // Read data stand until the next read strobe.
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= `ANR_RDATA_RESET;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mgmt_phy_address <= `ANR_ADDR_RESET;
        end else begin
            mgmt_phy_address <= addr_q;
        end
    end

    // The flag pins trail the read image by one cycle, the price of driving every output from a flop.
    // Fast full flag
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            res_fast_full_duplex <= `ANR_FLAG_RESET;
        end else begin
            res_fast_full_duplex <= res_r[`ANR_BIT_FFDX - `ANR_BIT_SHDX];
        end
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            res_fast_half_duplex <= `ANR_FLAG_RESET;
        end else begin
            res_fast_half_duplex <= res_r[`ANR_BIT_FHDX - `ANR_BIT_SHDX];
        end
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            res_slow_full_duplex <= `ANR_FLAG_RESET;
        end else begin
            res_slow_full_duplex <= res_r[`ANR_BIT_SFDX - `ANR_BIT_SHDX];
        end
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            res_slow_half_duplex <= `ANR_FLAG_RESET;
        end else begin
            res_slow_half_duplex <= res_r[`ANR_BIT_SHDX - `ANR_BIT_SHDX];
        end
    end
endmodule // anr_status_reg
`default_nettype wire

// ===== anr_status_reg_assertions.sv
// Port assertions for the result and address register.
`timescale 1ns/1ps
`default_nettype none
module anr_chk (
    input wire core_clk,
    input wire reset,
    input wire an_done,
    input wire [1:0] an_mode,
    input wire [3:0] an_progress,
    input wire reg_rd,
    input wire [4:0] reg_index,
    input wire [4:0] mgmt_phy_address,
    input wire [15:0] reg_rdata,
    input wire res_fast_full_duplex,
    input wire res_fast_half_duplex,
    input wire res_slow_full_duplex,
    input wire res_slow_half_duplex,
    input wire [3:0] autoneg_progress_code
);
    wire [3:0] fl = {res_fast_full_duplex, res_fast_half_duplex, res_slow_full_duplex, res_slow_half_duplex};
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_fast_full: assert property (an_done && an_mode == 2'h3 |-> ##2 fl[3]) else $error("ffd");
    a_fast_half: assert property (an_done && an_mode == 2'h2 |-> ##2 fl[2]) else $error("fhd");
    a_slow_full: assert property (an_done && an_mode == 2'h1 |-> ##2 fl[1]) else $error("sfd");
    a_slow_half: assert property (an_done && an_mode == 2'h0 |-> ##2 fl[0]) else $error("shd");
    a_flags_onehot: assert property (an_done |-> ##2 $onehot(fl)) else $error("onehot");
    a_reserved_zero: assert property (reg_rdata[11:9] == 3'h0) else $error("rsvd");
    a_code_follows: assert property (an_progress <= 4'h8 |=> autoneg_progress_code == $past(an_progress)) else $error("code");
    a_code_held: assert property (an_progress > 4'h8 |=> $stable(autoneg_progress_code)) else $error("held");
    a_addr_mirror: assert property (reg_rd && reg_index == 5'h11 |=> reg_rdata[8:4] == mgmt_phy_address) else $error("addr");
endmodule // anr_chk
bind anr_status_reg anr_chk chk_u (.*);
`default_nettype wire

// ===== anr_host.sv
// Management controller model issuing register accesses.
`timescale 1ns/1ps
`default_nettype none
module anr_host (
    input wire core_clk,
    input wire [15:0] reg_rdata,
    output logic [4:0] reg_index = 5'h0,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [15:0] reg_wdata = 16'h0
);
    task acc(input logic [4:0] idx, input logic w, input logic [15:0] d, output logic [15:0] q);
        @(negedge core_clk);
        reg_index = idx;
        reg_wr = w;
        reg_rd = !w;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~d;
        q = reg_rdata;
    endtask
endmodule // anr_host
`default_nettype wire

// ===== phy_autoneg_result_status_reg_bench.sv
// Self-checking bench for the result and address register.
`timescale 1ns/1ps
`default_nettype none
module phy_autoneg_result_status_reg_bench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic an_done = 1'b0;
    logic [1:0] an_mode = 2'h0;
    logic [3:0] an_progress = 4'h0;
    logic [15:0] q;
    wire [15:0] reg_rdata, reg_wdata;
    wire [4:0] reg_index;
    wire reg_wr, reg_rd;
    wire [4:0] mgmt_phy_address;
    wire [3:0] autoneg_progress_code;
    wire res_fast_full_duplex, res_fast_half_duplex, res_slow_full_duplex, res_slow_half_duplex;
    wire [3:0] flags = {res_fast_full_duplex, res_fast_half_duplex, res_slow_full_duplex, res_slow_half_duplex};
    int n_errors = 0, n_checks = 0, cyc = 0;
    anr_host host_u (.core_clk, .reg_rdata, .reg_index, .reg_wr, .reg_rd, .reg_wdata);
    anr_status_reg dut_u (.core_clk, .reset, .strap_phy_address(5'h15), .reg_index, .reg_wr, .reg_rd, .reg_wdata,
        .an_done, .an_mode, .an_progress, .reg_rdata, .mgmt_phy_address, .res_fast_full_duplex,
        .res_fast_half_duplex, .res_slow_full_duplex, .res_slow_half_duplex, .autoneg_progress_code);
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    task cmp(input logic [15:0] got, input logic [15:0] e);
        n_checks++;
        if (got !== e) begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, e);
        end
    endtask
    task chk(input logic [4:0] idx, input logic [15:0] e);
        host_u.acc(idx, 1'b0, 16'h0, q);
        cmp(q, e);
    endtask
    task t_reset_addr;
        repeat (6) @(negedge core_clk);
        chk(5'h11, 16'hF150);
        cmp({11'h0, mgmt_phy_address}, 16'h0015);
        cmp({12'h0, flags}, 16'h000F);
        host_u.acc(5'h11, 1'b1, 16'hF0AF, q);
        chk(5'h11, 16'hF0A0);
        cmp({11'h0, mgmt_phy_address}, 16'h000A);
        host_u.acc(5'h10, 1'b1, 16'h01F0, q);
        chk(5'h10, 16'h0000);
        chk(5'h11, 16'hF0A0);
    endtask
    task t_results;
        for (int i = 0; i < 10; i++) begin
            @(negedge core_clk);
            an_progress = 4'(i);
            an_mode = 2'(i);
            an_done = 1'b1;
            @(negedge core_clk);
            an_done = 1'b0;
            chk(5'h11, {4'h1 << an_mode, 8'h0A, (i > 8) ? 4'h8 : 4'(i)});
            cmp({12'h0, flags}, {12'h0, 4'h1 << an_mode});
            cmp({12'h0, autoneg_progress_code}, {12'h0, (i > 8) ? 4'h8 : 4'(i)});
        end
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        t_reset_addr;
        t_results;
        tally_and_finish;
    end
endmodule // phy_autoneg_result_status_reg_bench
`default_nettype wire
